// file: core/clk_synth_ctrl.sv
// digital control of the three-synthesizer clock generator
// Function
// - each synthesizer gets 8-bit pre-divider and 11-bit feedback divider settings
// - primary synth feeds crosspoint and a /2 /3 /4 fixed-ratio output
// - three select inputs choose one of eight programmed settings
// - first two outputs use 7-bit dividers from one shared slot choice
// - each select code maps to its own P/Q pair and slot choice
// - select-driven divider changes produce no glitch or runt pulse
// - crystal drive strength comes from a stored configuration field
// - six-bit load capacitance field, 0.375 pF steps, 6 to 30 pF
// - driven reference mode bypasses load caps; source leaves feedback pin open
// - crosspoint routes any of four sources to any 7-bit divider
// - third and fourth outputs use one fixed divider setting each
// - buffered reference output is the undivided reference
// - shutdown/output-enable low tristates all clock outputs
// - with full shutdown, pin low also stops synths, counters, oscillator
// - after full shutdown, synth clocks count only once relocked
// - suspend low disables a programmed subset of outputs and synths
// - a suspended synth never leaves its outputs enabled
// - suspended synth stops its logic; suspended output only tristates
// - an output may use the inverted phase of its synthesizer
// - third select pin may serve as active-low suspend input
// - output-enable-only mode tristates outputs, keeps chip running
//
// Local design decisions: the Avalon-MM slave port and the register addresses.
`timescale 1ns/100ps
module clk_synth_ctrl (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rst,
   // avalon-mm slave
   input wire logic [clk_synth_pkg::ADDR_W-1:0] i_address,
   input wire logic i_read,
   input wire logic i_write,
   input wire logic [clk_synth_pkg::DATA_W-1:0] i_writedata,
   input wire logic [3:0] i_byteenable,
   output logic [clk_synth_pkg::DATA_W-1:0] o_readdata,
   output logic o_waitrequest,
   // control pins
   input wire logic i_freq_select_bit0,
   input wire logic i_freq_select_bit1,
   input wire logic i_freq_select_bit2_or_suspend_n,
   input wire logic i_shutdown_oe_n,
   // clock sources and lock indications
   input wire logic i_crystal_input,
   input wire logic i_primary_synth_clk,
   input wire logic i_second_synth_clk,
   input wire logic i_third_synth_clk,
   input wire logic i_primary_synth_lock,
   input wire logic i_second_synth_lock,
   input wire logic i_third_synth_lock,
   // synthesizer settings
   output logic [clk_synth_pkg::Q_W-1:0] o_primary_synth_pre_div,
   output logic [clk_synth_pkg::P_W-1:0] o_primary_synth_fb_div,
   output logic [clk_synth_pkg::Q_W-1:0] o_second_synth_pre_div,
   output logic [clk_synth_pkg::P_W-1:0] o_second_synth_fb_div,
   output logic [clk_synth_pkg::Q_W-1:0] o_third_synth_pre_div,
   output logic [clk_synth_pkg::P_W-1:0] o_third_synth_fb_div,
   output logic [2:0] o_synth_run,
   // oscillator settings
   output logic o_osc_run,
   output logic [clk_synth_pkg::DRIVE_W-1:0] o_drive_strength,
   output logic [clk_synth_pkg::CAP_W-1:0] o_cap_load,
   output logic o_cap_bypass,
   // clock output pins
   output logic o_out_clock_first,
   output logic o_out_clock_first_oe,
   output logic o_out_clock_second,
   output logic o_out_clock_second_oe,
   output logic o_out_clock_third,
   output logic o_out_clock_third_oe,
   output logic o_out_clock_fourth,
   output logic o_out_clock_fourth_oe,
   output logic o_out_clock_fixed_ratio,
   output logic o_out_clock_fixed_ratio_oe,
   output logic o_reference_buffer_out,
   output logic o_reference_buffer_out_oe
);
   import clk_synth_pkg::*;

   // register file
   logic [31:0] ctrl_q;
   logic [31:0] susp_q;
   logic [31:0] xp_q;
   logic [31:0] div_fixed_q;
   logic [31:0] div_slot_q [2];
   logic [31:0] sel_tbl_q [N_SEL];
   logic [31:0] second_q;
   logic [31:0] third_q;
   // bus
   logic wait_q;
   logic [31:0] rdata_q;
   logic [31:0] rdata_d;
   logic bus_req;
   logic bus_take;
   // pin synchronisers
   logic [N_PIN-1:0] pin_raw;
   logic [N_PIN-1:0] pin_s1_q;
   logic [N_PIN-1:0] pin_s2_q;
   logic [N_PIN-1:0] pin_s3_q;
   logic [N_PIN-1:0] pin_lvl_q;
   logic [N_PIN-1:0] pin_ok;
   logic [2:0] sel_code;
   logic oe_pin;
   logic susp_pin;
   logic [2:0] lock_lvl;
   logic [N_SRC-1:0] src_lvl;
   logic [N_SRC-1:0] src_rise;
   logic [N_SRC-1:0] src_fall;
   // power state
   logic full_sd;
   logic susp_act;
   logic [2:0] syn_off;
   logic [N_SRC-1:0] src_valid_q;
   logic [N_DIV:0] out_off_q;
   logic [N_DIV:0] out_off_d;
   logic slot_sel;
   // dividers
   logic [1:0] div_src [N_DIV];
   logic [N_DIV-1:0] div_inv;
   logic [DIV_W-1:0] div_target [N_DIV];
   logic [DIV_W-1:0] div_act_q [N_DIV];
   logic [DIV_W-1:0] cnt_q [N_DIV];
   logic [N_DIV-1:0] clk_q;
   logic [N_DIV-1:0] oe_q;
   logic ref_q;
   logic ref_oe_q;
   logic [DIV_W-1:0] fixed_div;

   // one wait cycle per request
   assign bus_req = i_read | i_write;
   assign bus_take = bus_req & ~wait_q;

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         wait_q <= 1'b1;
         rdata_q <= 32'h0000_0000;
      end else if (bus_take) begin
         wait_q <= 1'b1;
      end else if (bus_req) begin
         wait_q <= 1'b0;
         rdata_q <= i_read ? rdata_d : 32'h0000_0000;
      end
   end

   always_comb begin
      rdata_d = 32'h0000_0000;
      if (i_address >= OFS_SEL_BASE && i_address <= OFS_SEL_LAST && i_address[1:0] == 2'h0) begin
         rdata_d = sel_tbl_q[3'(i_address[4:2] - OFS_SEL_BASE[4:2])];
      end else begin
         case (i_address)
            OFS_CTRL: rdata_d = ctrl_q;
            OFS_SUSPEND: rdata_d = susp_q;
            OFS_XPOINT: rdata_d = xp_q;
            OFS_DIV_FIXED: rdata_d = div_fixed_q;
            OFS_DIV_SLOT0: rdata_d = div_slot_q[0];
            OFS_DIV_SLOT1: rdata_d = div_slot_q[1];
            OFS_SECOND: rdata_d = second_q;
            OFS_THIRD: rdata_d = third_q;
            OFS_STATUS: rdata_d = {22'h000000, src_valid_q, full_sd, susp_act, slot_sel, sel_code};
            default: rdata_d = 32'h0000_0000;
         endcase
      end
   end

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (be[b]) begin
            r[b*8 +: 8] = wd[b*8 +: 8];
         end
      end
      return r;
   endfunction

   // writes land at the edge waitrequest is seen low
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         ctrl_q <= CTRL_RST;
         susp_q <= SUSP_RST;
         xp_q <= XP_RST;
         div_fixed_q <= DIV_RST;
         div_slot_q[0] <= DIV_RST;
         div_slot_q[1] <= DIV_RST;
         second_q <= SYN_RST;
         third_q <= SYN_RST;
         for (int k = 0; k < N_SEL; k++) begin
            sel_tbl_q[k] <= SYN_RST;
         end
      end else if (bus_take && i_write) begin
         case (i_address)
            OFS_CTRL: ctrl_q <= merge(ctrl_q, i_writedata, i_byteenable);
            OFS_SUSPEND: susp_q <= merge(susp_q, i_writedata, i_byteenable);
            OFS_XPOINT: xp_q <= merge(xp_q, i_writedata, i_byteenable);
            OFS_DIV_FIXED: div_fixed_q <= merge(div_fixed_q, i_writedata, i_byteenable);
            OFS_DIV_SLOT0: div_slot_q[0] <= merge(div_slot_q[0], i_writedata, i_byteenable);
            OFS_DIV_SLOT1: div_slot_q[1] <= merge(div_slot_q[1], i_writedata, i_byteenable);
            OFS_SECOND: second_q <= merge(second_q, i_writedata, i_byteenable);
            OFS_THIRD: third_q <= merge(third_q, i_writedata, i_byteenable);
            default: begin
               for (int k = 0; k < N_SEL; k++) begin
                  if (i_address == OFS_SEL_BASE + 8'(4 * k)) begin
                     sel_tbl_q[k] <= merge(sel_tbl_q[k], i_writedata, i_byteenable);
                  end
               end
            end
         endcase
      end
   end

   // three-stage pin synchronisers
   assign pin_raw = {i_third_synth_clk, i_second_synth_clk, i_primary_synth_clk, i_crystal_input,
      i_third_synth_lock, i_second_synth_lock, i_primary_synth_lock, i_shutdown_oe_n,
      i_freq_select_bit2_or_suspend_n, i_freq_select_bit1, i_freq_select_bit0};

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         pin_s1_q <= '0;
         pin_s2_q <= '0;
         pin_s3_q <= '0;
      end else begin
         pin_s1_q <= pin_raw;
         pin_s2_q <= pin_s1_q;
         pin_s3_q <= pin_s2_q;
      end
   end

   generate
      for (genvar g = 0; g < N_PIN; g++) begin : g_pin
         assign pin_ok[g] = pin_s2_q[g] == pin_s3_q[g];
         always_ff @(posedge i_clk) begin
            if (i_rst) begin
               pin_lvl_q[g] <= 1'b0;
            end else if (pin_ok[g]) begin
               pin_lvl_q[g] <= pin_s3_q[g];
            end
         end
      end
   endgenerate

   assign oe_pin = pin_lvl_q[3];
   assign lock_lvl = pin_lvl_q[6:4];
   assign src_lvl = pin_lvl_q[10:7];
   assign src_rise = pin_ok[10:7] & pin_s3_q[10:7] & ~pin_lvl_q[10:7];
   assign src_fall = pin_ok[10:7] & ~pin_s3_q[10:7] & pin_lvl_q[10:7];
   // third pin: select bit two or suspend
   assign sel_code = {pin_lvl_q[2] & ~ctrl_q[CTRL_SUSP_EN], pin_lvl_q[1:0]};
   assign susp_pin = ctrl_q[CTRL_SUSP_EN] & ~pin_lvl_q[2];

   // power control
   assign full_sd = ctrl_q[CTRL_FULL_SD] & ~oe_pin;
   assign susp_act = susp_pin;
   assign syn_off = {3{susp_act}} & susp_q[SUSP_SYN_LSB +: 3];
   assign slot_sel = sel_tbl_q[sel_code][SLOT_BIT];

   // synthesizer and oscillator settings
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_primary_synth_pre_div <= '0;
         o_primary_synth_fb_div <= '0;
         o_second_synth_pre_div <= '0;
         o_second_synth_fb_div <= '0;
         o_third_synth_pre_div <= '0;
         o_third_synth_fb_div <= '0;
         o_synth_run <= 3'h0;
         o_osc_run <= 1'b0;
         o_drive_strength <= '0;
         o_cap_load <= '0;
         o_cap_bypass <= 1'b0;
      end else begin
         o_primary_synth_pre_div <= sel_tbl_q[sel_code][Q_W-1:0];
         o_primary_synth_fb_div <= sel_tbl_q[sel_code][P_LSB +: P_W];
         o_second_synth_pre_div <= second_q[Q_W-1:0];
         o_second_synth_fb_div <= second_q[P_LSB +: P_W];
         o_third_synth_pre_div <= third_q[Q_W-1:0];
         o_third_synth_fb_div <= third_q[P_LSB +: P_W];
         o_synth_run <= ~syn_off & {3{~full_sd}};
         o_osc_run <= ~full_sd;
         o_drive_strength <= ctrl_q[CTRL_DRIVE_LSB +: DRIVE_W];
         o_cap_load <= ctrl_q[CTRL_CAP_LSB +: CAP_W];
         o_cap_bypass <= ctrl_q[CTRL_BYPASS];
      end
   end

   // a synth source counts only once relocked
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         src_valid_q <= '0;
      end else begin
         src_valid_q[0] <= o_osc_run;
         src_valid_q[3:1] <= o_synth_run & lock_lvl;
      end
   end

   // per-output divider routing
   always_comb begin
      case (ctrl_q[CTRL_FIXDIV_LSB +: 2])
         FIX_DIV2: fixed_div = DIV_TWO;
         FIX_DIV3: fixed_div = DIV_THREE;
         default: fixed_div = DIV_FOUR;
      endcase
   end

   generate
      for (genvar g = 0; g < N_DIV; g++) begin : g_route
         if (g < 4) begin : g_xp
            assign div_src[g] = xp_q[2*g +: 2];
            assign div_inv[g] = xp_q[XP_INV_LSB + g];
         end else begin : g_fix
            assign div_src[g] = 2'h1;
            assign div_inv[g] = 1'b0;
         end
         if (g < 2) begin : g_ab
            assign div_target[g] = div_slot_q[slot_sel][g*DIV_HI_LSB +: DIV_W];
         end else if (g < 4) begin : g_cd
            assign div_target[g] = div_fixed_q[(g-2)*DIV_HI_LSB +: DIV_W];
         end else begin : g_e
            assign div_target[g] = fixed_div;
         end
      end
   endgenerate

   // a suspended synth disables every output it feeds
   always_comb begin
      for (int i = 0; i < N_DIV; i++) begin
         out_off_d[i] = susp_act & susp_q[i];
         if (div_src[i] != 2'h0 && syn_off[2'(div_src[i] - 2'h1)]) begin
            out_off_d[i] = 1'b1;
         end
      end
      out_off_d[N_DIV] = susp_act & susp_q[N_DIV];
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         out_off_q <= '1;
      end else begin
         out_off_q <= out_off_d;
      end
   end

   // output dividers step on the chosen source edge
   generate
      for (genvar g = 0; g < N_DIV; g++) begin : g_div
         logic tick;
         logic run;
         logic [DIV_W-1:0] half;
         assign tick = div_inv[g] ? src_fall[div_src[g]] : src_rise[div_src[g]];
         assign run = src_valid_q[div_src[g]] & ~full_sd;
         assign half = DIV_W'(({1'b0, div_act_q[g]} + 8'h01) >> 1);
         always_ff @(posedge i_clk) begin
            if (i_rst) begin
               cnt_q[g] <= '0;
               div_act_q[g] <= 7'h01;
               clk_q[g] <= 1'b0;
            end else if (!run) begin
               cnt_q[g] <= '0;
               div_act_q[g] <= div_target[g];
               clk_q[g] <= 1'b0;
            end else if (div_act_q[g] <= 7'h01) begin
               clk_q[g] <= src_lvl[div_src[g]] ^ div_inv[g];
               if (tick) begin
                  div_act_q[g] <= div_target[g];
               end
            end else if (tick) begin
               if (cnt_q[g] >= div_act_q[g] - 7'h01) begin
                  cnt_q[g] <= '0;
                  div_act_q[g] <= div_target[g];
                  clk_q[g] <= 1'b1;
               end else begin
                  cnt_q[g] <= cnt_q[g] + 7'h01;
                  clk_q[g] <= (cnt_q[g] + 7'h01) < half;
               end
            end
         end
         always_ff @(posedge i_clk) begin
            if (i_rst) begin
               oe_q[g] <= 1'b0;
            end else begin
               oe_q[g] <= oe_pin & ~out_off_q[g];
            end
         end
      end
   endgenerate

   // undivided buffered reference
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         ref_q <= 1'b0;
         ref_oe_q <= 1'b0;
      end else begin
         ref_q <= src_lvl[0] & src_valid_q[0];
         ref_oe_q <= oe_pin & ~out_off_q[N_DIV];
      end
   end

   assign o_readdata = rdata_q;
   assign o_waitrequest = wait_q;
   assign o_out_clock_first = clk_q[0];
   assign o_out_clock_first_oe = oe_q[0];
   assign o_out_clock_second = clk_q[1];
   assign o_out_clock_second_oe = oe_q[1];
   assign o_out_clock_third = clk_q[2];
   assign o_out_clock_third_oe = oe_q[2];
   assign o_out_clock_fourth = clk_q[3];
   assign o_out_clock_fourth_oe = oe_q[3];
   assign o_out_clock_fixed_ratio = clk_q[4];
   assign o_out_clock_fixed_ratio_oe = oe_q[4];
   assign o_reference_buffer_out = ref_q;
   assign o_reference_buffer_out_oe = ref_oe_q;
endmodule

// file: core/clk_synth_pkg.sv
// constants for the three-synthesizer clock control block
package clk_synth_pkg;
   // avalon slave geometry
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   // register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_SUSPEND = 8'h04;
   localparam logic [7:0] OFS_XPOINT = 8'h08;
   localparam logic [7:0] OFS_DIV_FIXED = 8'h0c;
   localparam logic [7:0] OFS_DIV_SLOT0 = 8'h10;
   localparam logic [7:0] OFS_DIV_SLOT1 = 8'h14;
   localparam logic [7:0] OFS_SEL_BASE = 8'h18;
   localparam logic [7:0] OFS_SEL_LAST = 8'h34;
   localparam logic [7:0] OFS_SECOND = 8'h38;
   localparam logic [7:0] OFS_THIRD = 8'h3c;
   localparam logic [7:0] OFS_STATUS = 8'h40;
   // control register fields
   localparam int CTRL_FULL_SD = 0;
   localparam int CTRL_SUSP_EN = 1;
   localparam int CTRL_BYPASS = 2;
   localparam int CTRL_DRIVE_LSB = 3;
   localparam int DRIVE_W = 3;
   localparam int CTRL_CAP_LSB = 6;
   localparam int CAP_W = 6;
   localparam int CTRL_FIXDIV_LSB = 12;
   // suspend register: outputs in low bits, synths above
   localparam int SUSP_OUT_W = 6;
   localparam int SUSP_SYN_LSB = 6;
   // crosspoint: 2-bit source per output, then invert bits
   localparam int XP_INV_LSB = 8;
   // synthesizer setting fields
   localparam int Q_W = 8;
   localparam int P_W = 11;
   localparam int P_LSB = 8;
   localparam int SLOT_BIT = 19;
   // divider geometry
   localparam int DIV_W = 7;
   localparam int DIV_HI_LSB = 8;
   localparam int N_DIV = 5;
   localparam int N_SRC = 4;
   localparam int N_SEL = 8;
   // pin synchroniser width: sel 3, oe 1, lock 3, sources 4
   localparam int N_PIN = 11;
   // reset values
   localparam logic [31:0] CTRL_RST = 32'h0000_1000;
   localparam logic [31:0] SUSP_RST = 32'h0000_0000;
   localparam logic [31:0] XP_RST = 32'h0000_0000;
   localparam logic [31:0] DIV_RST = 32'h0000_0101;
   localparam logic [31:0] SYN_RST = 32'h0000_0101;
   // fixed-ratio divisor codes
   localparam logic [1:0] FIX_DIV2 = 2'h0;
   localparam logic [1:0] FIX_DIV3 = 2'h1;
   localparam logic [6:0] DIV_TWO = 7'h02;
   localparam logic [6:0] DIV_THREE = 7'h03;
   localparam logic [6:0] DIV_FOUR = 7'h04;
endpackage

// file: tb/synth_src_model.sv
// crystal and synthesizer source model
`timescale 1ns/100ps
module synth_src_model (
   // run enables from the block
   input wire logic i_osc_run,
   input wire logic [2:0] i_synth_run,
   // source clocks and lock levels
   output logic o_crystal_input,
   output logic [2:0] o_synth_clk,
   output logic [2:0] o_synth_lock
);
   // reference drives only the input pin, feedback pin left open
   // stopped oscillator gives no edges
   initial begin
      o_crystal_input = 1'b0;
      forever begin
         #100;
         o_crystal_input = (i_osc_run === 1'b1) ? ~o_crystal_input : 1'b0;
      end
   end
   for (genvar k = 0; k < 3; k++) begin : g_syn
      initial begin
         o_synth_clk[k] = 1'b0;
         forever begin
            #(150 + 50 * k);
            o_synth_clk[k] = (i_synth_run[k] === 1'b1) ? ~o_synth_clk[k] : 1'b0;
         end
      end
      // lock returns only after a relock time
      initial o_synth_lock[k] = 1'b0;
      always @(i_synth_run[k]) begin
         o_synth_lock[k] = 1'b0;
         if (i_synth_run[k] === 1'b1) #2000 o_synth_lock[k] = (i_synth_run[k] === 1'b1);
      end
   end
endmodule

// file: tb/clk_synth_ctrl_assertions.sv
// concurrent checks on the control block ports
`timescale 1ns/100ps
module clk_synth_ctrl_assertions (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rst,
   // register bus
   input wire logic [clk_synth_pkg::ADDR_W-1:0] i_address,
   input wire logic i_write,
   input wire logic [clk_synth_pkg::DATA_W-1:0] i_writedata,
   input wire logic [3:0] i_byteenable,
   input wire logic o_waitrequest,
   // pins
   input wire logic i_freq_select_bit2_or_suspend_n,
   input wire logic i_shutdown_oe_n,
   input wire logic i_crystal_input,
   // observed outputs
   input wire logic [2:0] o_synth_run,
   input wire logic o_osc_run,
   input wire logic [clk_synth_pkg::DRIVE_W-1:0] o_drive_strength,
   input wire logic [clk_synth_pkg::CAP_W-1:0] o_cap_load,
   input wire logic o_cap_bypass,
   input wire logic o_out_clock_first,
   input wire logic o_out_clock_first_oe,
   input wire logic o_out_clock_second_oe,
   input wire logic o_out_clock_third_oe,
   input wire logic o_out_clock_fourth_oe,
   input wire logic o_out_clock_fixed_ratio_oe,
   input wire logic o_reference_buffer_out,
   input wire logic o_reference_buffer_out_oe
);
   import clk_synth_pkg::*;
   logic [31:0] ctrl_q;
   logic [8:0] susp_q;
   logic wr_ok;
   logic ctrl_wr;
   logic any_oe;
   assign wr_ok = i_write && !o_waitrequest && (i_byteenable == 4'hf);
   assign ctrl_wr = wr_ok && (i_address == OFS_CTRL);
   assign any_oe = |{o_out_clock_first_oe, o_out_clock_second_oe, o_out_clock_third_oe,
                     o_out_clock_fourth_oe, o_out_clock_fixed_ratio_oe, o_reference_buffer_out_oe};
   // bus-written control and suspend shadows
   always_ff @(posedge i_clk) begin
      if (i_rst) ctrl_q <= CTRL_RST;
      else if (ctrl_wr) ctrl_q <= i_writedata;
   end
   always_ff @(posedge i_clk) begin
      if (i_rst) susp_q <= SUSP_RST[8:0];
      else if (wr_ok && (i_address == OFS_SUSPEND)) susp_q <= i_writedata[8:0];
   end
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_rst);
   AST_DRIVE: assert property (ctrl_wr |=> ##[0:2]
      o_drive_strength == ctrl_q[CTRL_DRIVE_LSB +: DRIVE_W]) else $error("drive strength off");
   AST_CAP: assert property (ctrl_wr |=> ##[0:2]
      o_cap_load == ctrl_q[CTRL_CAP_LSB +: CAP_W]) else $error("cap load off");
   AST_BYPASS: assert property (ctrl_wr |=> ##[0:2]
      o_cap_bypass == ctrl_q[CTRL_BYPASS]) else $error("cap bypass off");
   AST_OE_OFF: assert property ((!i_shutdown_oe_n)[*7] |-> !any_oe)
      else $error("output driven while disabled");
   AST_FULL_SD: assert property ((ctrl_q[CTRL_FULL_SD] && !i_shutdown_oe_n)[*7] |->
      !o_osc_run && o_synth_run == 3'h0) else $error("running in shutdown");
   AST_OE_ONLY: assert property ((!ctrl_q[CTRL_FULL_SD] && !i_shutdown_oe_n)[*7] |-> o_osc_run)
      else $error("oscillator stopped");
   AST_SUSPEND: assert property ((ctrl_q[CTRL_SUSP_EN] && !i_freq_select_bit2_or_suspend_n)[*7] |->
      (o_synth_run & susp_q[8:6]) == 3'h0 && !(susp_q[0] && o_out_clock_first_oe))
      else $error("suspend subset active");
   AST_REF: assert property ($rose(o_reference_buffer_out) |-> $past(i_crystal_input, 4))
      else $error("reference not followed");
   AST_RUNT_HI: assert property ($rose(o_out_clock_first) |=>
      (o_out_clock_first || !o_out_clock_first_oe)[*3]) else $error("short high phase");
   AST_RUNT_LO: assert property ($fell(o_out_clock_first) |=>
      (!o_out_clock_first || !o_out_clock_first_oe)[*3]) else $error("short low phase");
endmodule
bind clk_synth_ctrl clk_synth_ctrl_assertions clk_synth_ctrl_assertions_i (.*);

// file: tb/clk_synth_ctrl_tb_top.sv
// self-checking bench for the control block
`timescale 1ns/100ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin bad_count++; \
   $display("unexpected at %0t: got %h expected %h", $time, (g), (e)); end end
module clk_synth_ctrl_tb_top;
   import clk_synth_pkg::*;
   logic i_clk, i_rst, i_read, i_write, i_shutdown_oe_n, i_crystal_input;
   logic i_freq_select_bit0, i_freq_select_bit1, i_freq_select_bit2_or_suspend_n;
   logic [7:0] i_address;
   logic [31:0] i_writedata, o_readdata, r, gv, ev;
   logic [3:0] i_byteenable;
   logic o_waitrequest, o_osc_run, o_cap_bypass;
   logic [7:0] o_primary_synth_pre_div, o_second_synth_pre_div, o_third_synth_pre_div;
   logic [10:0] o_primary_synth_fb_div, o_second_synth_fb_div, o_third_synth_fb_div;
   logic [2:0] o_synth_run, o_drive_strength, sclk, slock;
   logic [5:0] o_cap_load;
   logic o_out_clock_first, o_out_clock_first_oe, o_out_clock_second, o_out_clock_second_oe;
   logic o_out_clock_third, o_out_clock_third_oe, o_out_clock_fourth, o_out_clock_fourth_oe;
   logic o_out_clock_fixed_ratio, o_out_clock_fixed_ratio_oe, o_reference_buffer_out, o_reference_buffer_out_oe;
   wire i_primary_synth_clk = sclk[0];
   wire i_second_synth_clk = sclk[1];
   wire i_third_synth_clk = sclk[2];
   wire i_primary_synth_lock = slock[0];
   wire i_second_synth_lock = slock[1];
   wire i_third_synth_lock = slock[2];
   wire [5:0] oes = {o_reference_buffer_out_oe, o_out_clock_fixed_ratio_oe, o_out_clock_fourth_oe,
                     o_out_clock_third_oe, o_out_clock_second_oe, o_out_clock_first_oe};
   wire [5:0] clks = {o_reference_buffer_out, o_out_clock_fixed_ratio, o_out_clock_fourth,
                      o_out_clock_third, o_out_clock_second, o_out_clock_first};
   int msel, bad_count, checks, n;
   wire mclk = clks[msel];
   logic [31:0] exp_q[$];
   logic [31:0] got_q[$];
   logic [7:0] q [8];
   logic [10:0] p [8];
   realtime t0;
   clk_synth_ctrl clk_synth_ctrl_i (.*);
   synth_src_model synth_src_model_i (.i_osc_run(o_osc_run), .i_synth_run(o_synth_run),
      .o_crystal_input(i_crystal_input), .o_synth_clk(sclk), .o_synth_lock(slock));
   initial begin
      i_clk = 1'b0;
      forever #12.5 i_clk = ~i_clk;
   end
   task tally_and_finish;
      if (bad_count == 0 && checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task note(input logic [31:0] g, input logic [31:0] e);
      exp_q.push_back(e);
      got_q.push_back(g);
   endtask
   // avalon transfer; reads expect d
   task bus(input logic rd, input logic [7:0] a, input logic [31:0] d);
      i_address <= a;
      i_writedata <= d;
      i_read <= rd;
      i_write <= !rd;
      if (rd) exp_q.push_back(d);
      do @(posedge i_clk); while (o_waitrequest !== 1'b0);
      i_read <= 1'b0;
      i_write <= 1'b0;
      @(posedge i_clk);
   endtask
   task pins(input logic [2:0] c);
      {i_freq_select_bit2_or_suspend_n, i_freq_select_bit1, i_freq_select_bit0} <= c;
      repeat (10) @(posedge i_clk);
   endtask
   // output period in clock cycles
   task meas(input int m, input logic [31:0] e);
      msel = m;
      repeat (3) @(posedge mclk);
      t0 = $realtime;
      @(posedge mclk);
      note(32'(int'(($realtime - t0) / 25.0)), e);
   endtask
   always @(posedge i_clk) begin
      if (i_read === 1'b1 && o_waitrequest === 1'b0) begin
         ev = exp_q.pop_front();
         `CHK(o_readdata, ev)
      end
      while (got_q.size() > 0) begin
         gv = got_q.pop_front();
         ev = exp_q.pop_front();
         `CHK(gv, ev)
      end
   end
   initial begin
      #1_000_000;
      bad_count++;
      tally_and_finish;
   end
   initial begin
      {i_rst, i_read, i_write, i_shutdown_oe_n} = 4'b1001;
      {i_freq_select_bit2_or_suspend_n, i_freq_select_bit1, i_freq_select_bit0} = 3'b000;
      i_address = 8'h00;
      i_writedata = 32'h0;
      i_byteenable = 4'hf;
      msel = 0;
      r = $urandom(32'h4756);
      repeat (5) @(posedge i_clk);
      i_rst <= 1'b0;
      @(posedge i_clk);
      bus(1, OFS_CTRL, CTRL_RST);
      bus(1, OFS_SUSPEND, SUSP_RST);
      bus(1, OFS_XPOINT, XP_RST);
      for (int k = 0; k < 13; k++) bus(1, OFS_DIV_FIXED + 8'(4 * k), k < 3 ? DIV_RST : SYN_RST);
      r = $urandom();
      bus(0, 8'h80, r);
      bus(1, 8'h80, 32'h0);
      r = $urandom() & 32'h0000_0ffc;
      bus(0, OFS_CTRL, r);
      bus(1, OFS_CTRL, r);
      note({o_drive_strength, o_cap_load, o_cap_bypass}, {r[5:3], r[11:6], r[2]});
      for (int k = 0; k < N_SEL; k++) begin
         q[k] = 8'($urandom_range(255, 1));
         p[k] = 11'($urandom());
         bus(0, OFS_SEL_BASE + 8'(4 * k), {12'h0, k[0], p[k], q[k]});
      end
      for (int k = 0; k < N_SEL; k++) begin
         pins(3'(k));
         note({o_primary_synth_pre_div, o_primary_synth_fb_div}, {q[k], p[k]});
      end
      r = $urandom();
      bus(0, OFS_SECOND, r);
      bus(0, OFS_THIRD, ~r);
      repeat (2) @(posedge i_clk);
      note({o_second_synth_pre_div, o_second_synth_fb_div}, {r[7:0], r[18:8]});
      note({o_third_synth_pre_div, o_third_synth_fb_div}, {~r[7:0], ~r[18:8]});
      bus(0, OFS_DIV_SLOT0, 32'h0000_0202);
      bus(0, OFS_DIV_SLOT1, 32'h0000_0503);
      pins(3'd0);
      for (int s = 0; s < N_SRC; s++) begin
         bus(0, OFS_XPOINT, 32'(s));
         meas(0, 32'(16 + 8 * s));
      end
      pins(3'd1);
      meas(0, 32'd60);
      meas(1, 32'd40);
      bus(0, OFS_DIV_FIXED, 32'h0000_0604);
      bus(0, OFS_XPOINT, 32'h0000_0093);
      meas(2, 32'd48);
      meas(3, 32'd96);
      pins(3'd0);
      meas(2, 32'd48);
      for (int c = 0; c < 3; c++) begin
         bus(0, OFS_CTRL, 32'(c) << CTRL_FIXDIV_LSB);
         meas(4, 32'(24 + 12 * c));
      end
      meas(5, 32'd8);
      bus(0, OFS_XPOINT, 32'h0000_0205);
      meas(1, 32'd24);
      @(posedge o_out_clock_first);
      t0 = $realtime;
      @(posedge o_out_clock_second);
      note(32'(int'(($realtime - t0) / 25.0) % 12), 32'd6);
      i_shutdown_oe_n <= 1'b0;
      repeat (10) @(posedge i_clk);
      note({oes, o_osc_run}, 7'h01);
      i_shutdown_oe_n <= 1'b1;
      bus(0, OFS_CTRL, 32'h0000_0001);
      i_shutdown_oe_n <= 1'b0;
      repeat (10) @(posedge i_clk);
      note({oes, o_osc_run, o_synth_run}, 10'h0);
      i_shutdown_oe_n <= 1'b1;
      n = 0;
      repeat (40) begin
         @(posedge i_clk);
         n += int'(o_out_clock_first);
      end
      note(32'(n), 32'd0);
      meas(0, 32'd24);
      pins(3'b100);
      bus(0, OFS_CTRL, 32'h0000_0002);
      bus(0, OFS_XPOINT, 32'h0000_00c1);
      bus(0, OFS_SUSPEND, 32'h0000_0101);
      pins(3'b000);
      note({oes[3:0], o_synth_run}, 7'b0110_011);
      pins(3'b100);
      note({oes[0], o_synth_run}, 4'hf);
      tally_and_finish;
   end
endmodule
